// *** pcsi_pkg.sv ***
package pcsi_pkg;

  // ==========================================================================
  // Widths
  localparam int PC_W = 13;
  localparam int TGT_W = 11;
  localparam int LATCH_W = 5;
  localparam int DATA_W = 8;
  localparam int IND_ADDR_W = 9;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;

  // ==========================================================================
  // Register byte addresses on the bus
  localparam logic [11:0] OFF_PC_LOW = 12'h000;
  localparam logic [11:0] OFF_PC_LATCH = 12'h004;
  localparam logic [11:0] OFF_IND_PTR = 12'h008;
  localparam logic [11:0] OFF_IND_PORT = 12'h00C;

  // ==========================================================================
  // Field positions
  localparam int LATCH_PAGE_HI = 4;
  localparam int LATCH_PAGE_LO = 3;

  // ==========================================================================
  // Reset values
  localparam logic [PC_W-1:0] RST_PC = 13'h0000;
  localparam logic [LATCH_W-1:0] RST_LATCH = 5'h00;
  localparam logic [DATA_W-1:0] RST_PTR = 8'h00;
  localparam logic [SP_W-1:0] RST_SP = 3'h0;

  // Data-space address that the indirect port itself occupies
  localparam logic [DATA_W-1:0] IND_SELF_ADDR = 8'h00;
  localparam logic [DATA_W-1:0] IND_SELF_READ = 8'h00;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [SP_W-1:0] SP_ONE = 3'h1;

  // ==========================================================================
  // Core commands
  typedef enum logic [5:0] {
    OP_STEP = 6'b00_0001,
    OP_JUMP = 6'b00_0010,
    OP_CALL = 6'b00_0100,
    OP_RETURN = 6'b00_1000,
    OP_IRQ = 6'b01_0000,
    OP_NONE = 6'b10_0000
  } pcsi_op_t;

  typedef struct packed {
    logic valid;
    pcsi_op_t op;
    logic [TGT_W-1:0] target;
  } pcsi_cmd_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [IND_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pcsi_dm_req_t;

  // ==========================================================================
  // Bus slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEM = 3'b010,
    ST_RESP = 3'b100
  } pcsi_state_t;

endpackage

// *** pcsi_core.sv ***
`timescale 1ns/1ns
// Contract
// - Program counter is 13 bits; its low byte is software read/write.
// - Upper five counter bits are hidden; software writes them only through the high latch.
// - Low-byte write loads the byte and copies latch bits 4..0 upward.
// - Jump and call take 11 target bits plus latch bit 3; counter bit 12 is forced to zero.
// - Call pushes its return address before loading the target.
// - Interrupt branch pushes the full current counter.
// - Any return pops the top entry into the whole counter.
// - Stack holds eight 13-bit entries; its pointer is invisible to software.
// - Push and pop leave the high latch untouched.
// - Stack is circular; ninth push overwrites the first, silently.
// - Latch bit 4 plays no part in paging.
// - Indirect port has no storage; accesses go to the pointed register.
// - Indirect read with pointer zero returns 00h.
// - Indirect write aimed at the port itself stores nothing.
// - Indirect address is 9 bits; the bank bit above is unused, zero.
module pcsi_core (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pcsi_pkg::pcsi_cmd_t core_cmd,
  output logic [pcsi_pkg::PC_W-1:0] fetch_addr,
  output pcsi_pkg::pcsi_dm_req_t dm_req,
  input wire logic dm_ack,
  input wire logic [pcsi_pkg::DATA_W-1:0] dm_rdata
);

  // ==========================================================================
  // Address decode
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = addr_is(a, pcsi_pkg::OFF_PC_LOW) || addr_is(a, pcsi_pkg::OFF_PC_LATCH) ||
      addr_is(a, pcsi_pkg::OFF_IND_PTR) || addr_is(a, pcsi_pkg::OFF_IND_PORT);
  endfunction

  // ==========================================================================
  // Paging
  // Latch bit 4 ignored
  // Jumps and calls stay in the low 4K words; bit 4 only reaches the counter on low-byte writes.
  function automatic logic [pcsi_pkg::PC_W-1:0] paged_target(
    input logic [pcsi_pkg::LATCH_W-1:0] latch,
    input logic [pcsi_pkg::TGT_W-1:0] target
  );
    paged_target = {1'b0, latch[pcsi_pkg::LATCH_PAGE_LO], target};
  endfunction

  // ==========================================================================
  // State
  logic [pcsi_pkg::PC_W-1:0] pc_reg;
  logic [pcsi_pkg::LATCH_W-1:0] latch_reg;
  logic [pcsi_pkg::DATA_W-1:0] ptr_reg;
  logic [pcsi_pkg::SP_W-1:0] sp_reg;
  logic [pcsi_pkg::PC_W-1:0] stack_reg [pcsi_pkg::STACK_DEPTH];
  pcsi_pkg::pcsi_state_t state_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  pcsi_pkg::pcsi_dm_req_t dm_reg;

  logic setup;
  logic commit;
  logic pc_low_wr;
  logic push;
  logic pop;
  logic [pcsi_pkg::PC_W-1:0] push_val;
  logic [pcsi_pkg::SP_W-1:0] sp_below;
  logic [pcsi_pkg::PC_W-1:0] pc_next;
  logic [pcsi_pkg::IND_ADDR_W-1:0] ind_addr;
  logic ind_self;
  logic ind_mem;
  logic latch_wr;
  logic ptr_wr;

  assign setup = psel && !penable;
  assign commit = psel && penable && pready_reg && !pslverr_reg;
  assign pc_low_wr = commit && pwrite && addr_is(paddr, pcsi_pkg::OFF_PC_LOW);
  assign latch_wr = commit && pwrite && addr_is(paddr, pcsi_pkg::OFF_PC_LATCH);
  assign ptr_wr = commit && pwrite && addr_is(paddr, pcsi_pkg::OFF_IND_PTR);
  assign ind_addr = {1'b0, ptr_reg};
  assign ind_self = (ptr_reg == pcsi_pkg::IND_SELF_ADDR);
  assign ind_mem = addr_is(paddr, pcsi_pkg::OFF_IND_PORT) && !ind_self;
  assign sp_below = sp_reg - pcsi_pkg::SP_ONE;

  // ==========================================================================
  // Next program counter and stack moves
  // A low-byte write from software wins over a core command in the same cycle.
  always_comb begin
    pc_next = pc_reg;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_reg;
    if (pc_low_wr) begin
      pc_next = {latch_reg, pwdata[pcsi_pkg::DATA_W-1:0]};
    end else if (core_cmd.valid) begin
      case (core_cmd.op)
        pcsi_pkg::OP_STEP: begin
          pc_next = pc_reg + pcsi_pkg::PC_ONE;
        end
        pcsi_pkg::OP_JUMP: begin
          pc_next = paged_target(latch_reg, core_cmd.target);
        end
        pcsi_pkg::OP_CALL: begin
          push = 1'b1;
          push_val = pc_reg + pcsi_pkg::PC_ONE;
          pc_next = paged_target(latch_reg, core_cmd.target);
        end
        pcsi_pkg::OP_RETURN: begin
          pop = 1'b1;
          pc_next = stack_reg[sp_below];
        end
        pcsi_pkg::OP_IRQ: begin
          push = 1'b1;
          push_val = pc_reg;
          pc_next = pcsi_pkg::IRQ_VECTOR;
        end
        default: begin
          pc_next = pc_reg;
        end
      endcase
    end
  end

  // ==========================================================================
  // Program counter
  // Software sets upper bits only via latch paths
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pc_reg <= pcsi_pkg::RST_PC;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // ==========================================================================
  // Hardware stack
  // Pointer wraps, no overflow flag
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sp_reg <= pcsi_pkg::RST_SP;
    end else if (push) begin
      sp_reg <= sp_reg + pcsi_pkg::SP_ONE;
    end else if (pop) begin
      sp_reg <= sp_below;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < pcsi_pkg::STACK_DEPTH; gi++) begin : g_stack
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          stack_reg[gi] <= pcsi_pkg::RST_PC;
        end else if (push && (sp_reg == pcsi_pkg::SP_W'(gi))) begin
          stack_reg[gi] <= push_val;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Software registers
  // Latch written by software only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      latch_reg <= pcsi_pkg::RST_LATCH;
    end else if (latch_wr) begin
      latch_reg <= pwdata[pcsi_pkg::LATCH_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_reg <= pcsi_pkg::RST_PTR;
    end else if (ptr_wr) begin
      ptr_reg <= pwdata[pcsi_pkg::DATA_W-1:0];
    end
  end

  // ==========================================================================
  // Bus slave
  // Access phase lasts one cycle, longer only while the data memory is busy.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= pcsi_pkg::ST_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        pcsi_pkg::ST_IDLE: begin
          if (setup) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= !addr_mapped(paddr);
            if (ind_mem) begin
              state_reg <= pcsi_pkg::ST_MEM;
            end else begin
              pready_reg <= 1'b1;
              state_reg <= pcsi_pkg::ST_RESP;
              if (addr_is(paddr, pcsi_pkg::OFF_PC_LOW)) begin
                prdata_reg <= {24'h00_0000, pc_reg[pcsi_pkg::DATA_W-1:0]};
              end else if (addr_is(paddr, pcsi_pkg::OFF_PC_LATCH)) begin
                prdata_reg <= {27'h000_0000, latch_reg};
              end else if (addr_is(paddr, pcsi_pkg::OFF_IND_PTR)) begin
                prdata_reg <= {24'h00_0000, ptr_reg};
              end else if (addr_is(paddr, pcsi_pkg::OFF_IND_PORT)) begin
                prdata_reg <= {24'h00_0000, pcsi_pkg::IND_SELF_READ};
              end
            end
          end
        end
        pcsi_pkg::ST_MEM: begin
          if (dm_ack) begin
            prdata_reg <= dm_reg.we ? 32'h0000_0000 : {24'h00_0000, dm_rdata};
            pready_reg <= 1'b1;
            state_reg <= pcsi_pkg::ST_RESP;
          end
        end
        pcsi_pkg::ST_RESP: begin
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          state_reg <= pcsi_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= pcsi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Data memory request
  // Redirect to pointed register
  // Held as a level until acknowledged, so a slow memory needs no extra handshake.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dm_reg <= '0;
    end else if ((state_reg == pcsi_pkg::ST_IDLE) && setup && ind_mem) begin
      dm_reg.req <= 1'b1;
      dm_reg.we <= pwrite;
      dm_reg.addr <= ind_addr;
      dm_reg.wdata <= pwdata[pcsi_pkg::DATA_W-1:0];
    end else if ((state_reg == pcsi_pkg::ST_MEM) && dm_ack) begin
      dm_reg.req <= 1'b0;
      dm_reg.we <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign fetch_addr = pc_reg;
  assign dm_req = dm_reg;

endmodule

// *** pcsi_core_properties.sv ***
`timescale 1ns/1ns
module pcsi_core_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pcsi_pkg::pcsi_cmd_t core_cmd,
  input wire logic [pcsi_pkg::PC_W-1:0] fetch_addr,
  input wire pcsi_pkg::pcsi_dm_req_t dm_req,
  input wire logic dm_ack,
  input wire logic [pcsi_pkg::DATA_W-1:0] dm_rdata
);
  // ==========================================================================
  // Shadows of software registers
  logic [4:0] latch_reg;
  logic [7:0] ptr_reg;
  logic apb_wr, pcl_wr, ind_setup, is_step, is_jump, is_call, is_ret, is_irq;
  logic [1:0] page;
  logic [7:0] wbyte;
  assign apb_wr = psel && penable && pwrite && pready && !pslverr;
  assign pcl_wr = apb_wr && paddr == pcsi_pkg::OFF_PC_LOW;
  assign ind_setup = psel && !penable && paddr == pcsi_pkg::OFF_IND_PORT;
  // Low-byte write wins over a command
  assign is_step = core_cmd.valid && core_cmd.op == pcsi_pkg::OP_STEP && !pcl_wr;
  assign is_jump = core_cmd.valid && core_cmd.op == pcsi_pkg::OP_JUMP && !pcl_wr;
  assign is_call = core_cmd.valid && core_cmd.op == pcsi_pkg::OP_CALL && !pcl_wr;
  assign is_ret = core_cmd.valid && core_cmd.op == pcsi_pkg::OP_RETURN && !pcl_wr;
  assign is_irq = core_cmd.valid && core_cmd.op == pcsi_pkg::OP_IRQ && !pcl_wr;
  assign page = {1'b0, latch_reg[3]};
  assign wbyte = pwdata[7:0];
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      latch_reg <= pcsi_pkg::RST_LATCH;
    end else if (apb_wr && paddr == pcsi_pkg::OFF_PC_LATCH) begin
      latch_reg <= pwdata[4:0];
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_reg <= pcsi_pkg::RST_PTR;
    end else if (apb_wr && paddr == pcsi_pkg::OFF_IND_PTR) begin
      ptr_reg <= pwdata[7:0];
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_step_adv: assert property (
    is_step |=> fetch_addr == $past(fetch_addr) + pcsi_pkg::PC_ONE)
    else $error("counter did not advance by one");
  chk_jump_page: assert property (
    is_jump |=> fetch_addr == {$past(page), $past(core_cmd.target)})
    else $error("jump target or page wrong");
  chk_low_write: assert property (
    pcl_wr |=> fetch_addr == {$past(latch_reg), $past(wbyte)})
    else $error("low byte write loaded wrong counter");
  chk_irq_vector: assert property (
    is_irq |=> fetch_addr == pcsi_pkg::IRQ_VECTOR)
    else $error("interrupt branch went astray");
  chk_call_return: assert property (
    is_call ##1 is_ret |=> fetch_addr == $past(fetch_addr, 2) + pcsi_pkg::PC_ONE)
    else $error("return did not restore call address");
  chk_self_read: assert property (
    ind_setup && !pwrite && ptr_reg == 8'h00 |=> pready && prdata == 32'h0000_0000 && !dm_req.req)
    else $error("self read not zero");
  chk_ind_redirect: assert property (
    ind_setup && ptr_reg != 8'h00 |=> dm_req.req && dm_req.addr == {1'b0, $past(ptr_reg)})
    else $error("indirect access not redirected");
  chk_self_write: assert property (
    ind_setup && pwrite && ptr_reg == 8'h00 |=> pready && !dm_req.req)
    else $error("self write reached memory");
  cover property (is_call ##1 is_ret);
  cover property (ind_setup && ptr_reg != 8'h00);
  cover property (pready && pslverr);
endmodule
bind pcsi_core pcsi_core_properties pcsi_core_properties_inst (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_cmd(core_cmd),
  .fetch_addr(fetch_addr), .dm_req(dm_req), .dm_ack(dm_ack), .dm_rdata(dm_rdata));

// *** tb_pcsi_core.sv ***
`timescale 1ns/1ns
module tb_pcsi_core;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, dm_ack, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] dm_rdata;
  logic [12:0] fetch_addr, m;
  logic [12:0] push_q [9];
  pcsi_pkg::pcsi_cmd_t core_cmd;
  pcsi_pkg::pcsi_dm_req_t dm_req, dm_seen;
  int n_mismatch = 0;
  int checks_done = 0;
  int dcnt = 0;
  int dm_n = 0;
  int k;
  pcsi_core pcsi_core_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_cmd(core_cmd), .fetch_addr(fetch_addr),
    .dm_req(dm_req), .dm_ack(dm_ack), .dm_rdata(dm_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // Slow data memory; idle data bus shows the inverse
  assign dm_rdata = dm_ack ? 8'h5A : 8'hA5;
  always @(posedge clk_sys) begin
    if (dm_req.req && !dm_ack && dcnt == 2) begin
      dm_ack <= 1'b1;
      dm_seen <= dm_req;
      dm_n <= dm_n + 1;
      dcnt <= 0;
    end else begin
      dm_ack <= 1'b0;
      dcnt <= (dm_req.req && !dm_ack) ? dcnt + 1 : 0;
    end
  end
  // ==========================================================================
  // Shared tasks
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cmd(input pcsi_pkg::pcsi_op_t op, input logic [10:0] t, input logic [12:0] e);
    @(posedge clk_sys);
    core_cmd <= '{1'b1, op, t};
    @(posedge clk_sys);
    core_cmd <= '{1'b0, pcsi_pkg::OP_NONE, 11'h000};
    #1 cmp("fetch_addr", {19'h0, e}, {19'h0, fetch_addr});
  endtask
  // ==========================================================================
  // Scenarios
  task t_regs;
    #1 cmp("reset pc", 32'h0000_0000, {19'h0, fetch_addr});
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp("slverr", 32'h0000_0001, {31'h0, err});
    apb(1'b1, pcsi_pkg::OFF_PC_LATCH, 32'h0000_001A);
    #1 cmp("pc held", 32'h0000_0000, {19'h0, fetch_addr});
    apb(1'b1, pcsi_pkg::OFF_PC_LOW, 32'h0000_003C);
    #1 cmp("low write", 32'h0000_1A3C, {19'h0, fetch_addr});
    apb(1'b0, pcsi_pkg::OFF_PC_LOW, 32'h0000_0000);
    cmp("pc_low", 32'h0000_003C, rd);
    cmd(pcsi_pkg::OP_STEP, 11'h000, 13'h1A3D);
    cmd(pcsi_pkg::OP_JUMP, 11'h123, 13'h0923);
  endtask
  task t_stack;
    m = 13'h0923;
    for (k = 0; k < 9; k++) begin
      push_q[k] = m + 13'h0001;
      m = {2'b01, 11'(16 + 8 * k)};
      cmd(pcsi_pkg::OP_CALL, 11'(16 + 8 * k), m);
    end
    for (k = 0; k < 9; k++) begin
      m = push_q[(k < 8) ? 8 - k : 8];
      cmd(pcsi_pkg::OP_RETURN, 11'h000, m);
    end
    cmd(pcsi_pkg::OP_IRQ, 11'h000, pcsi_pkg::IRQ_VECTOR);
    cmd(pcsi_pkg::OP_RETURN, 11'h000, m);
    @(posedge clk_sys);
    core_cmd <= '{1'b1, pcsi_pkg::OP_CALL, 11'h7FF};
    @(posedge clk_sys);
    core_cmd <= '{1'b1, pcsi_pkg::OP_RETURN, 11'h000};
    cmd(pcsi_pkg::OP_STEP, 11'h000, m + 13'h0002);
    apb(1'b0, pcsi_pkg::OFF_PC_LATCH, 32'h0000_0000);
    cmp("latch", 32'h0000_001A, rd);
  endtask
  task t_ind;
    apb(1'b1, pcsi_pkg::OFF_IND_PTR, 32'h0000_0005);
    apb(1'b0, pcsi_pkg::OFF_IND_PORT, 32'h0000_0000);
    cmp("ind read", 32'h0000_005A, rd);
    apb(1'b1, pcsi_pkg::OFF_IND_PORT, 32'h0000_0077);
    cmp("dm_req", {13'h0, 19'h6_0577}, {13'h0, dm_seen});
    apb(1'b1, pcsi_pkg::OFF_IND_PTR, 32'h0000_0000);
    apb(1'b0, pcsi_pkg::OFF_IND_PORT, 32'h0000_0000);
    cmp("self read", 32'h0000_0000, rd);
    apb(1'b1, pcsi_pkg::OFF_IND_PORT, 32'h0000_0099);
    cmp("dm count", 32'h0000_0002, 32'(dm_n));
  endtask
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    dm_ack = 1'b0;
    core_cmd = '{1'b0, pcsi_pkg::OP_NONE, 11'h000};
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_stack;
    t_ind;
    stop_test;
  end
  // Hang guard well beyond the hundred or so cycles used
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    stop_test;
  end
endmodule
